// *** clk_mode_ctrl.sv ***
// CPU clock mode register, clock divider and oscillation stop reset
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module clk_mode_ctrl
#(
  parameter int OSD_TIMEOUT = clk_mode_pkg::OSD_TIMEOUT_CYC
)
(
  input  wire logic                              I_CLK,
  input  wire logic                              I_RESETN,
  input  wire clk_mode_pkg::wb_req_s             I_WB,
  output logic                                   O_WB_ACK,
  output logic [clk_mode_pkg::WB_DAT_W-1:0]      O_WB_DAT,
  input  wire logic                              I_EXT_OSC,
  output logic                                   O_PHI_TICK,
  output clk_mode_pkg::clk_src_e                 O_CLK_SRC,
  output logic [1:0]                             O_PROC_MODE,
  output logic                                   O_EXT_OSC_EN,
  output logic                                   O_ONCHIP_OSC_EN,
  output logic                                   O_INT_RESET,
  output logic                                   O_IRQ
);
  import clk_mode_pkg::*;

  // Bus decode
  logic              req;
  logic              wr;
  logic              lane0;
  logic              hit_mode;
  logic              hit_osd;
  logic              hit_stat;
  logic              hit_mask;
  logic              hit_clk;
  logic              hit_set;
  logic              hit_clr;
  logic [7:0]        wdat;
  logic              ack_reg;
  logic [WB_DAT_W-1:0] rdat_reg;
  logic [WB_DAT_W-1:0] rdat_next;
  logic [WB_DAT_W-1:0] rd_mode;
  logic [WB_DAT_W-1:0] rd_osd;
  logic [WB_DAT_W-1:0] rd_stat;
  logic [WB_DAT_W-1:0] rd_mask;
  logic [WB_DAT_W-1:0] rd_clk;

  // Mode register state
  logic [7:0]        mode_reg;
  logic [7:0]        mode_next;
  logic              locked_reg;
  logic              locked_next;
  logic              mode_wr;
  logic              set_wr;
  logic              clr_wr;
  logic              any_mode_op;
  logic [7:0]        mode_new;
  logic              lock_event;

  // Oscillation stop detection
  logic              osd_en_reg;
  logic              osd_en_next;
  logic              osd_flag_reg;
  logic              osd_flag_next;
  logic              osd_wr;
  logic              osd_arm;
  logic              stop_pulse;
  logic              int_rst_reg;

  // Interrupts
  logic [IRQ_W-1:0]  int_stat_reg;
  logic [IRQ_W-1:0]  int_stat_next;
  logic [IRQ_W-1:0]  int_mask_reg;
  logic [IRQ_W-1:0]  int_events;
  logic [IRQ_W-1:0]  int_clear;
  logic              irq_reg;

  // Clock divider and outputs
  logic [1:0]        div_sel;
  logic [2:0]        ratio;
  logic [2:0]        div_cnt_reg;
  logic [2:0]        div_cnt_next;
  logic              tick_reg;
  logic              tick_next;
  clk_src_e          src_reg;
  clk_src_e          src_next;
  logic [1:0]        proc_reg;
  logic              ext_en_reg;
  logic              onchip_en_reg;

  assign req      = I_WB.cyc && I_WB.stb && !ack_reg;
  assign wr       = req && I_WB.we;
  assign lane0    = I_WB.sel[0];
  assign wdat     = I_WB.dat[7:0];
  assign hit_mode = (I_WB.adr == MODE_OFS);
  assign hit_osd  = (I_WB.adr == OSD_OFS);
  assign hit_stat = (I_WB.adr == INT_STAT_OFS);
  assign hit_mask = (I_WB.adr == INT_MASK_OFS);
  assign hit_clk  = (I_WB.adr == CLK_STAT_OFS);
  assign hit_set  = (I_WB.adr == MODE_SET_OFS);
  assign hit_clr  = (I_WB.adr == MODE_CLR_OFS);

  // Plain write, bit set and bit clear all land in the mode register
  assign mode_wr  = wr && lane0 && hit_mode;
  assign set_wr   = wr && lane0 && hit_set && (wdat != 8'h00);
  assign clr_wr   = wr && lane0 && hit_clr && (wdat != 8'h00);
  assign any_mode_op = mode_wr || set_wr || clr_wr;

  assign mode_new = mode_wr ? wdat
                  : set_wr  ? (mode_reg | wdat)
                  : clr_wr  ? (mode_reg & ~wdat)
                  : mode_reg;

  // Locked bits keep their value silently; free bits still update
  assign mode_next = locked_reg
                   ? ((mode_new & MODE_FREE_MASK) | (mode_reg & MODE_LOCK_MASK))
                   : mode_new;
  // A plain mode write or a nonzero bit op closes the lock, including a bit op on free bits
  assign locked_next = locked_reg || any_mode_op;
  assign lock_event  = any_mode_op && !locked_reg;

  // Detect enable and stop flag
  assign osd_wr      = wr && lane0 && hit_osd;
  assign osd_en_next = osd_wr ? wdat[OSD_EN_BIT] : osd_en_reg;
  // Stop event wins over a simultaneous clearing write
  assign osd_flag_next = stop_pulse ? 1'b1
                       : (osd_wr && !wdat[OSD_EN_BIT]) ? 1'b0
                       : osd_flag_reg;
  // Needs the on-chip oscillator as the sensing reference
  assign osd_arm = osd_en_reg && !mode_reg[ONCHIP_STOP_BIT]
                && !mode_reg[EXT_STOP_BIT] && !stop_pulse;

  assign int_events = {lock_event, stop_pulse};
  assign int_clear  = (wr && lane0 && hit_stat) ? wdat[IRQ_W-1:0] : '0;
  assign int_stat_next = int_events | (int_stat_reg & ~int_clear);

  // Clock division
  assign div_sel = mode_reg[DIV_MSB:DIV_LSB];
  assign ratio   = (div_sel == DIV_DOUBLE) ? RATIO_DOUBLE
                 : (div_sel == DIV_HIGH)   ? RATIO_HIGH
                 : RATIO_MIDDLE;
  assign tick_next    = (div_cnt_reg >= ratio);
  assign div_cnt_next = tick_next ? 3'h0 : div_cnt_reg + 3'h1;

  // Clock source: on-chip until software moves to the external one
  assign src_next = !mode_reg[MAIN_EXT_BIT] ? SRC_ONCHIP
                  : mode_reg[OSC_SEL_BIT]  ? SRC_RC
                  : SRC_CERAMIC;

  // Read words: 8-bit registers sit in the low lane, upper bits read zero
  assign rd_mode = {{(WB_DAT_W-8){1'b0}}, mode_reg};
  assign rd_osd  = {{(WB_DAT_W-2){1'b0}}, osd_flag_reg, osd_en_reg};
  assign rd_stat = {{(WB_DAT_W-IRQ_W){1'b0}}, int_stat_reg};
  assign rd_mask = {{(WB_DAT_W-IRQ_W){1'b0}}, int_mask_reg};
  // Source field is four bits wide so the lock flag lands on bit 6
  assign rd_clk  = {{(WB_DAT_W-7){1'b0}}, locked_reg, 4'(src_reg),
                    div_sel};

  // Zero outside a request keeps the data lines quiet between answers
  assign rdat_next = !req ? '0
                   : hit_mode ? rd_mode
                   : hit_osd  ? rd_osd
                   : hit_stat ? rd_stat
                   : hit_mask ? rd_mask
                   : hit_clk  ? rd_clk
                   : '0;

  osc_stop_detect
  #(
    .TIMEOUT_CYC (OSD_TIMEOUT)
  )
  u_osd
  (
    .i_clk     (I_CLK),
    .i_resetn  (I_RESETN),
    .i_ext_osc (I_EXT_OSC),
    .i_arm     (osd_arm),
    .o_stop    (stop_pulse)
  );

  // Bus answer: one wait state, unmapped reads return zero
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= '0;
    end
    else
    begin
      ack_reg  <= req;
      rdat_reg <= rdat_next;
    end
  end

  // Internal reset re-inits the mode state but never the stop flag
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      mode_reg     <= MODE_RESET;
      locked_reg   <= 1'b0;
      osd_en_reg   <= 1'b0;
      osd_flag_reg <= 1'b0;
      int_rst_reg  <= 1'b0;
    end
    else if (stop_pulse)
    begin
      mode_reg     <= MODE_RESET;
      locked_reg   <= 1'b0;
      osd_en_reg   <= 1'b0;
      osd_flag_reg <= 1'b1;
      int_rst_reg  <= 1'b1;
    end
    else
    begin
      mode_reg     <= mode_next;
      locked_reg   <= locked_next;
      osd_en_reg   <= osd_en_next;
      osd_flag_reg <= osd_flag_next;
      int_rst_reg  <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      int_stat_reg <= '0;
      int_mask_reg <= '0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      int_stat_reg <= int_stat_next;
      if (wr && lane0 && hit_mask)
      begin
        int_mask_reg <= wdat[IRQ_W-1:0];
      end
      irq_reg <= |(int_stat_next & int_mask_reg);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      div_cnt_reg   <= 3'h0;
      tick_reg      <= 1'b0;
      src_reg       <= SRC_ONCHIP;
      proc_reg      <= 2'h0;
      ext_en_reg    <= 1'b1;
      onchip_en_reg <= 1'b1;
    end
    else
    begin
      div_cnt_reg   <= div_cnt_next;
      tick_reg      <= tick_next;
      src_reg       <= src_next;
      proc_reg      <= {mode_reg[PROC1_BIT], mode_reg[PROC0_BIT]};
      ext_en_reg    <= !mode_reg[EXT_STOP_BIT];
      onchip_en_reg <= !mode_reg[ONCHIP_STOP_BIT];
    end
  end

  assign O_WB_ACK        = ack_reg;
  assign O_WB_DAT        = rdat_reg;
  assign O_PHI_TICK      = tick_reg;
  assign O_CLK_SRC       = src_reg;
  assign O_PROC_MODE     = proc_reg;
  assign O_EXT_OSC_EN    = ext_en_reg;
  assign O_ONCHIP_OSC_EN = onchip_en_reg;
  assign O_INT_RESET     = int_rst_reg;
  assign O_IRQ           = irq_reg;
endmodule
`default_nettype wire

// *** clk_mode_ctrl_sva.sv ***
// Port checker for the clock mode and oscillation stop block
`timescale 1ns/100ps
`default_nettype none
module clk_mode_ctrl_chk
  import clk_mode_pkg::*;
#(
  parameter int OSD_TIMEOUT = OSD_TIMEOUT_CYC
)
(
  input wire logic     I_CLK,
  input wire logic     I_RESETN,
  input wire wb_req_s  I_WB,
  input wire logic     O_WB_ACK,
  input wire logic [WB_DAT_W-1:0] O_WB_DAT,
  input wire logic     I_EXT_OSC,
  input wire logic     O_PHI_TICK,
  input wire clk_src_e O_CLK_SRC,
  input wire logic [1:0] O_PROC_MODE,
  input wire logic     O_EXT_OSC_EN,
  input wire logic     O_ONCHIP_OSC_EN,
  input wire logic     O_INT_RESET,
  input wire logic     O_IRQ
);
  logic        osc_q_reg;
  logic [15:0] still_reg;
  logic [4:0]  gap_reg;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  // Counters saturate so a long idle stretch never wraps to a small value
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      osc_q_reg <= 1'b0;
      still_reg <= 16'h0000;
      gap_reg   <= 5'h00;
    end
    else
    begin
      osc_q_reg <= I_EXT_OSC;
      still_reg <= (I_EXT_OSC != osc_q_reg) ? 16'h0000 :
                   still_reg + {15'h0, ~&still_reg};
      gap_reg   <= O_PHI_TICK ? 5'h00 : gap_reg + {4'h0, ~&gap_reg};
    end
  end
  chk_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");
  chk_ack_answer: assert property (I_WB.cyc && I_WB.stb && !O_WB_ACK
    |=> O_WB_ACK) else $error("request not answered next cycle");
  chk_dat_idle: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h00000000)
    else $error("read data not zero outside ack");
  chk_irst_pulse: assert property (O_INT_RESET |=> !O_INT_RESET)
    else $error("internal reset longer than one cycle");
  chk_irst_defaults: assert property (O_INT_RESET |=>
    O_CLK_SRC == SRC_ONCHIP && O_PROC_MODE == 2'h0 && O_EXT_OSC_EN
    && O_ONCHIP_OSC_EN) else $error("mode not restored by stop reset");
  chk_stop_delay: assert property (O_INT_RESET |->
    still_reg >= OSD_TIMEOUT) else $error("stop reset too early");
  chk_needs_onchip: assert property (
    (!O_ONCHIP_OSC_EN) [*3] |-> !O_INT_RESET)
    else $error("stop reset without on-chip oscillator");
  chk_proc_lock: assert property (O_PROC_MODE != $past(O_PROC_MODE)
    |-> $past(O_PROC_MODE) == 2'h0 || $past(O_INT_RESET))
    else $error("processor mode changed after lock");
  chk_tick_gap: assert property (gap_reg < 5'h10)
    else $error("internal clock tick missing");
  cov_stop: cover property (O_INT_RESET);
  cov_irq: cover property (O_IRQ);
  cov_write: cover property (O_WB_ACK && I_WB.we);
endmodule
bind clk_mode_ctrl clk_mode_ctrl_chk #(.OSD_TIMEOUT(OSD_TIMEOUT)) chk (
  .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_WB(I_WB), .O_WB_ACK(O_WB_ACK),
  .O_WB_DAT(O_WB_DAT), .I_EXT_OSC(I_EXT_OSC), .O_PHI_TICK(O_PHI_TICK),
  .O_CLK_SRC(O_CLK_SRC), .O_PROC_MODE(O_PROC_MODE),
  .O_EXT_OSC_EN(O_EXT_OSC_EN), .O_ONCHIP_OSC_EN(O_ONCHIP_OSC_EN),
  .O_INT_RESET(O_INT_RESET), .O_IRQ(O_IRQ));
`default_nettype wire

// *** clk_mode_pkg.sv ***
// Constants and carrier types for the CPU clock mode and oscillation stop block
// Function
// - Mode bits 5, 1, 0 accept one write after reset, later writes ignored.
// - Bit set or clear on bits 2-4, 6, 7 also locks bits 5, 1, 0.
// - Bits 7:6 divide ratio, bit 4 external stop, bit 3 on-chip stop.
// - Internal clock is input rate, half rate or one eighth rate.
// - Loss of external oscillation raises an internal reset.
// - Stop detection works only while the on-chip oscillator runs.
// - Oscillation stop reset keeps the stop status flag at one.
// - External reset clears the stop status flag to zero.
// - Writing zero to the detect enable bit clears the stop status flag.
// - After reset the clock comes from the on-chip oscillator; bit 5 picks type.
`default_nettype none
package clk_mode_pkg;

  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;

  // Word offsets on the register bus
  localparam logic [WB_ADR_W-1:0] MODE_OFS     = 8'h00;
  localparam logic [WB_ADR_W-1:0] OSD_OFS      = 8'h04;
  localparam logic [WB_ADR_W-1:0] INT_STAT_OFS = 8'h08;
  localparam logic [WB_ADR_W-1:0] INT_MASK_OFS = 8'h0C;
  localparam logic [WB_ADR_W-1:0] CLK_STAT_OFS = 8'h10;
  localparam logic [WB_ADR_W-1:0] MODE_SET_OFS = 8'h14;
  localparam logic [WB_ADR_W-1:0] MODE_CLR_OFS = 8'h18;

  // Mode register fields
  localparam int PROC0_BIT    = 0;
  localparam int PROC1_BIT    = 1;
  localparam int MAIN_EXT_BIT = 2;
  localparam int ONCHIP_STOP_BIT = 3;
  localparam int EXT_STOP_BIT = 4;
  localparam int OSC_SEL_BIT  = 5;
  localparam int DIV_LSB      = 6;
  localparam int DIV_MSB      = 7;
  localparam logic [7:0] MODE_LOCK_MASK = 8'h23;
  localparam logic [7:0] MODE_FREE_MASK = 8'hDC;
  localparam logic [7:0] MODE_RESET     = 8'h40;

  // Division ratio codes
  localparam logic [1:0] DIV_HIGH   = 2'h0;
  localparam logic [1:0] DIV_MIDDLE = 2'h1;
  localparam logic [1:0] DIV_DOUBLE = 2'h2;
  localparam logic [2:0] RATIO_DOUBLE = 3'h0;
  localparam logic [2:0] RATIO_HIGH   = 3'h1;
  localparam logic [2:0] RATIO_MIDDLE = 3'h7;

  // Oscillation stop control register fields
  localparam int OSD_EN_BIT   = 0;
  localparam int OSD_FLAG_BIT = 1;

  // Interrupt status bits
  localparam int IRQ_W         = 2;
  localparam int IRQ_STOP_BIT  = 0;
  localparam int IRQ_LOCK_BIT  = 1;

  // Oscillation stop timeout
  localparam int CLK_PERIOD_NS   = 50;
  localparam int OSD_TIMEOUT_NS  = 10000;
  localparam int OSD_TIMEOUT_CYC = OSD_TIMEOUT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SRC_ONCHIP,
    SRC_CERAMIC,
    SRC_RC
  } clk_src_e;

  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [WB_ADR_W-1:0] adr;
    logic [3:0]          sel;
    logic [WB_DAT_W-1:0] dat;
  } wb_req_s;

endpackage
`default_nettype wire

// *** osc_stop_detect.sv ***
// Watchdog on the external oscillation, sampled on the on-chip clock
`timescale 1ns/100ps
`default_nettype none
module osc_stop_detect
#(
  parameter int TIMEOUT_CYC = clk_mode_pkg::OSD_TIMEOUT_CYC
)
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ext_osc,
  input  wire logic i_arm,
  output logic      o_stop
);
  import clk_mode_pkg::*;

  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYC - 1);

  logic             sync1_reg;
  logic             sync2_reg;
  logic             prev_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             stop_reg;
  logic             edge_seen;
  logic             expired;

  assign edge_seen = sync2_reg ^ prev_reg;
  assign expired   = i_arm && !edge_seen && (cnt_reg == CNT_LAST);
  // Counter only runs while armed, so a disabled detector restarts clean
  assign cnt_next  = (!i_arm || edge_seen || expired) ? '0
                   : cnt_reg + CNT_W'(1);
  assign o_stop    = stop_reg;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
      cnt_reg   <= '0;
      stop_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg <= i_ext_osc;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      cnt_reg   <= cnt_next;
      stop_reg  <= expired;
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the clock mode and oscillation stop block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module testbench;
  import clk_mode_pkg::*;
  localparam int TMO = 8;
  logic        clk, rst_n, ext_osc, osc_run, ack, tick, irst, irq, xen, oen;
  logic [31:0] dat, rd;
  logic [1:0]  pm;
  clk_src_e    src;
  wb_req_s     req;
  int          n_mismatch, num_checks, n_irst, k;
  clk_mode_ctrl #(.OSD_TIMEOUT(TMO)) dut (.I_CLK(clk), .I_RESETN(rst_n),
    .I_WB(req), .O_WB_ACK(ack), .O_WB_DAT(dat), .I_EXT_OSC(ext_osc),
    .O_PHI_TICK(tick), .O_CLK_SRC(src), .O_PROC_MODE(pm),
    .O_EXT_OSC_EN(xen), .O_ONCHIP_OSC_EN(oen), .O_INT_RESET(irst),
    .O_IRQ(irq));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (osc_run) ext_osc <= ~ext_osc;
  // Counted on the falling edge so the main sequence reads a settled total
  always @(negedge clk) if (irst === 1'b1) n_irst++;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    i = 0;
    do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin n_mismatch++; report_and_stop(); end
    rd = dat;
    req <= '{1'b0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h00000000};
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h00000000);
    `CHECK(rd, e)
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk);
    `CHECK(irq, e)
  endtask
  task automatic gap(input int e);
    int n;
    repeat (10) @(posedge clk);
    n = 0;
    while (tick !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    n = 0;
    do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 20);
    `CHECK(n, e)
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic stop_osc(input int e);
    k = n_irst;
    osc_run <= 1'b0;
    repeat (40) @(posedge clk);
    `CHECK(n_irst - k, e)
  endtask
  initial
  begin
    rst_n = 1'b0; ext_osc = 1'b0; osc_run = 1'b1;
    req = '{1'b0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h00000000};
    n_mismatch = 0; num_checks = 0; n_irst = 0;
    do_reset();
    rdchk(MODE_OFS, 32'h00000040);
    rdchk(OSD_OFS, 32'h00000000);
    `CHECK(src, SRC_ONCHIP)
    `CHECK({xen, oen}, 2'h3)
    gap(8);
    wb(1'b1, MODE_OFS, 32'h00000085);
    rdchk(MODE_OFS, 32'h00000085);
    gap(1);
    `CHECK(src, SRC_CERAMIC)
    `CHECK(pm, 2'h1)
    wb(1'b1, MODE_OFS, 32'h00000026);
    rdchk(MODE_OFS, 32'h00000005);
    gap(2);
    rdchk(8'hFC, 32'h00000000);
    do_reset();
    wb(1'b1, MODE_CLR_OFS, 32'h00000040);
    wb(1'b1, MODE_OFS, 32'h00000023);
    rdchk(MODE_OFS, 32'h00000000);
    rdchk(INT_STAT_OFS, 32'h00000002);
    wb(1'b1, MODE_SET_OFS, 32'h00000004);
    rdchk(MODE_OFS, 32'h00000004);
    rdchk(CLK_STAT_OFS, 32'h00000044);
    wb(1'b1, INT_STAT_OFS, 32'h00000002);
    rdchk(INT_STAT_OFS, 32'h00000000);
    do_reset();
    wb(1'b1, MODE_SET_OFS, 32'h00000080);
    wb(1'b1, MODE_OFS, 32'h000000C3);
    rdchk(MODE_OFS, 32'h000000C0);
    do_reset();
    wb(1'b1, INT_MASK_OFS, 32'h00000001);
    wb(1'b1, OSD_OFS, 32'h00000001);
    k = n_irst;
    repeat (30) @(posedge clk);
    `CHECK(n_irst - k, 0)
    stop_osc(1);
    rdchk(OSD_OFS, 32'h00000002);
    rdchk(MODE_OFS, 32'h00000040);
    irqchk(1'b1);
    wb(1'b1, INT_MASK_OFS, 32'h00000000);
    irqchk(1'b0);
    wb(1'b1, INT_MASK_OFS, 32'h00000001);
    irqchk(1'b1);
    wb(1'b1, INT_STAT_OFS, 32'h00000001);
    irqchk(1'b0);
    rdchk(INT_STAT_OFS, 32'h00000000);
    wb(1'b1, OSD_OFS, 32'h00000000);
    rdchk(OSD_OFS, 32'h00000000);
    osc_run <= 1'b1;
    wb(1'b1, OSD_OFS, 32'h00000001);
    stop_osc(1);
    rdchk(OSD_OFS, 32'h00000002);
    do_reset();
    rdchk(OSD_OFS, 32'h00000000);
    osc_run <= 1'b1;
    wb(1'b1, MODE_OFS, 32'h0000000C);
    wb(1'b1, OSD_OFS, 32'h00000001);
    `CHECK({xen, oen}, 2'h2)
    `CHECK(src, SRC_CERAMIC)
    stop_osc(0);
    report_and_stop();
  end
endmodule
`default_nettype wire
